// >>> smi_pending_ext_battery_logic.sv
// SMI pending, external SMI request and battery-level SMI logic of the PMU.
// Assumes a CPU that reports its SMI handler as a level, a PMU that reports
// its mode and issues refresh pulses, and pins asynchronous to core_clk.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module smi_pending_ext_battery_logic #(
  parameter int unsigned NUM_IO = 5
) (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      clk_en,
  input  wire smi_pend_pkg::reg_req_t    reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire smi_pend_pkg::pin_group_t  pins,
  input  wire logic [NUM_IO-1:0]         io_decode_smi,
  input  wire logic                      smi_active,
  input  wire logic                      refresh_pulse,
  input  wire smi_pend_pkg::pmu_mode_t   pmu_mode,
  input  wire logic                      cpu_clock_stopped,
  output logic                           smi_request,
  output logic                           cpu_clock_force_run,
  output logic                           slow_clock_force,
  output logic                           force_step_down
);

  initial begin
    if (NUM_IO != smi_pend_pkg::NUM_IO_SRC) begin
      $error("NUM_IO must match the I/O decode field of the status register");
    end
  end

  // Register accesses
  logic wr_src_en;
  logic wr_func_en;
  logic wr_pmu_ctrl2;
  logic wr_mem_ctrl;
  logic wr_socket;
  logic wr_event;
  logic wr_reg_a;
  logic rd_event;

  assign wr_src_en    = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_SRC_ENABLE;
  assign wr_func_en   = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_FUNC_ENABLE;
  assign wr_pmu_ctrl2 = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_PMU_CTRL2;
  assign wr_mem_ctrl  = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_MEM_SPACE_CTRL;
  assign wr_socket    = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_SOCKET_STATUS;
  assign wr_event     = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_SMI_EVENT;
  assign wr_reg_a     = reg_req.wr && reg_req.addr == smi_pend_pkg::IDX_REGISTER_A;
  assign rd_event     = reg_req.rd && reg_req.addr == smi_pend_pkg::IDX_SMI_EVENT;

  // Pin synchronisers; the first stage feeds only the second
  smi_pend_pkg::pin_group_t pin_meta_q;
  smi_pend_pkg::pin_group_t pin_sync_q;
  smi_pend_pkg::pin_group_t pin_prev_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end else if (clk_en) begin
      pin_meta_q <= pins;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // Control registers
  logic [7:0] src_enable_q;
  logic [7:0] func_enable_q;
  logic [7:0] pmu_ctrl2_q;
  logic [7:0] mem_ctrl_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_enable_q  <= smi_pend_pkg::RST_SRC_ENABLE;
      func_enable_q <= smi_pend_pkg::RST_FUNC_ENABLE;
      pmu_ctrl2_q   <= smi_pend_pkg::RST_PMU_CTRL2;
      mem_ctrl_q    <= smi_pend_pkg::RST_MEM_SPACE_CTRL;
    end else if (clk_en) begin
      if (wr_src_en) begin
        src_enable_q <= reg_req.wdata;
      end
      if (wr_func_en) begin
        func_enable_q <= reg_req.wdata;
      end
      if (wr_pmu_ctrl2) begin
        pmu_ctrl2_q <= reg_req.wdata;
      end
      if (wr_mem_ctrl) begin
        mem_ctrl_q <= reg_req.wdata;
      end
    end
  end

  // External request input
  logic ext_enable;
  logic ext_pol_low;
  logic ext_level_active;
  logic ext_edge;

  assign ext_enable       = func_enable_q[smi_pend_pkg::FE_EXT_EN_BIT];
  assign ext_pol_low      = func_enable_q[smi_pend_pkg::FE_EXT_POL_BIT];
  assign ext_level_active = pin_sync_q.ext_req ^ ext_pol_low;
  assign ext_edge         = ext_enable && ext_level_active
                            && !(pin_prev_q.ext_req ^ ext_pol_low);

  // Battery channels: index 0 and 2 rearm on level, index 1 fires on falling edge
  logic [smi_pend_pkg::NUM_BATT-1:0] batt_lvl;
  logic [smi_pend_pkg::NUM_BATT-1:0] batt_prev;
  logic [smi_pend_pkg::NUM_BATT-1:0] batt_fire;
  logic [smi_pend_pkg::NUM_BATT-1:0] batt_fired_q;
  logic [smi_pend_pkg::NUM_BATT-1:0] batt_look_q;
  logic [smi_pend_pkg::NUM_BATT-1:0] event_q;
  logic                              bl2_masked;

  assign batt_lvl  = {pin_sync_q.bl3_n, pin_sync_q.bl2_n, pin_sync_q.bl1_n};
  assign batt_prev = {pin_prev_q.bl3_n, pin_prev_q.bl2_n, pin_prev_q.bl1_n};

  assign bl2_masked = pmu_mode == smi_pend_pkg::PMU_SLEEP
                      || pmu_mode == smi_pend_pkg::PMU_SUSPEND
                      || pmu_mode == smi_pend_pkg::PMU_OFF
                      || !pin_sync_q.bl4_n;

  genvar gi;
  generate
    for (gi = 0; gi < smi_pend_pkg::NUM_BATT; gi++) begin : g_batt
      logic enabled;
      assign enabled = src_enable_q[smi_pend_pkg::SE_BATT_BASE_BIT + gi];
      if (gi == 1) begin : g_edge
        assign batt_fire[gi] = enabled && !bl2_masked && !batt_fired_q[gi]
                               && batt_prev[gi] && !batt_lvl[gi];
      end else begin : g_level
        assign batt_fire[gi] = enabled && !batt_fired_q[gi]
                               && batt_lvl[gi] == batt_look_q[gi];
      end

      always_ff @(posedge core_clk) begin
        if (srst) begin
          batt_fired_q[gi] <= 1'b0;
          batt_look_q[gi]  <= 1'b0;
        end else if (clk_en) begin
          if (rd_event && batt_fired_q[gi]) begin
            batt_fired_q[gi] <= 1'b0;
            batt_look_q[gi]  <= ~batt_look_q[gi];
          end else if (batt_fire[gi]) begin
            batt_fired_q[gi] <= 1'b1;
          end
        end
      end

      // Set wins over a same-cycle write clear
      always_ff @(posedge core_clk) begin
        if (srst) begin
          event_q[gi] <= 1'b0;
        end else if (clk_en) begin
          if (batt_fire[gi]) begin
            event_q[gi] <= 1'b1;
          end else if (wr_event) begin
            event_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // PMU request, cleared by a socket status write; a new event wins
  logic pmu_req_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pmu_req_q <= 1'b0;
    end else if (clk_en) begin
      if (|batt_fire) begin
        pmu_req_q <= 1'b1;
      end else if (wr_socket) begin
        pmu_req_q <= 1'b0;
      end
    end
  end

  // I/O decode status bits, write one to clear, set wins
  logic [NUM_IO-1:0] io_status_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_status_q <= '0;
    end else if (clk_en) begin
      io_status_q <= io_decode_smi
                     | (io_status_q & ~(wr_reg_a ? reg_req.wdata[NUM_IO-1:0] : '0));
    end
  end

  // SMI sequencer
  smi_pend_pkg::smi_state_t smi_state_q;
  logic                     ext_pend_q;
  logic                     io_pend_q;
  logic                     any_req;

  assign any_req = ext_pend_q || io_pend_q || pmu_req_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      smi_state_q <= smi_pend_pkg::SMI_IDLE;
    end else if (clk_en) begin
      unique case (smi_state_q)
        smi_pend_pkg::SMI_IDLE: begin
          if (any_req) begin
            smi_state_q <= smi_pend_pkg::SMI_ASSERT;
          end
        end
        smi_pend_pkg::SMI_ASSERT: begin
          if (smi_active) begin
            smi_state_q <= smi_pend_pkg::SMI_SERVICE;
          end
        end
        smi_pend_pkg::SMI_SERVICE: begin
          if (!smi_active) begin
            // A still-active external level re-requests at once, not one cycle later via ext_pend_q
            smi_state_q <= (any_req || (ext_enable && ext_level_active)) ? smi_pend_pkg::SMI_ASSERT
                                                                         : smi_pend_pkg::SMI_IDLE;
          end
        end
        default: begin
          smi_state_q <= smi_pend_pkg::SMI_IDLE;
        end
      endcase
    end
  end

  // External pending: taken at acceptance, re-armed while the level stays active
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (ext_edge) begin
        ext_pend_q <= 1'b1;
      end else if (smi_state_q == smi_pend_pkg::SMI_SERVICE && !smi_active
                   && ext_enable && ext_level_active) begin
        ext_pend_q <= 1'b1;
      end else if (smi_state_q == smi_pend_pkg::SMI_ASSERT && smi_active) begin
        ext_pend_q <= 1'b0;
      end
    end
  end

  // I/O decodes only start an SMI when none is in service
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (smi_state_q == smi_pend_pkg::SMI_IDLE && |io_decode_smi) begin
        io_pend_q <= 1'b1;
      end else if (smi_state_q == smi_pend_pkg::SMI_ASSERT && smi_active) begin
        io_pend_q <= 1'b0;
      end
    end
  end

  assign smi_request = smi_state_q == smi_pend_pkg::SMI_ASSERT;

  // CPU clock hold: released on the refresh after an event register write
  logic clk_run_q;
  logic release_pend_q;
  logic run_start;

  assign run_start = batt_fire[0] || batt_fire[2]
                     || (batt_fire[1] && pmu_mode == smi_pend_pkg::PMU_DOZE
                         && cpu_clock_stopped);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      release_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_event) begin
        release_pend_q <= 1'b1;
      end else if (refresh_pulse) begin
        release_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      clk_run_q <= 1'b0;
    end else if (clk_en) begin
      if (run_start) begin
        clk_run_q <= 1'b1;
      end else if (refresh_pulse && release_pend_q) begin
        clk_run_q <= 1'b0;
      end
    end
  end

  assign cpu_clock_force_run = clk_run_q;

  // Slow clock and forced step-down toward Sleep
  logic slow_q;
  logic step_q;
  logic step_paused;
  logic step_wanted;

  assign step_paused = pmu_req_q
                       && ((pmu_mode == smi_pend_pkg::PMU_LOW
                            && src_enable_q[smi_pend_pkg::SE_LOW_DOZE_BIT])
                        || (pmu_mode == smi_pend_pkg::PMU_DOZE
                            && src_enable_q[smi_pend_pkg::SE_DOZE_SLEEP_BIT]));
  assign step_wanted = !pin_sync_q.bl2_n && !pin_sync_q.ac_present
                       && !mem_ctrl_q[smi_pend_pkg::MSC_NO_SLEEP_BIT]
                       && (pmu_mode == smi_pend_pkg::PMU_HIGH
                           || pmu_mode == smi_pend_pkg::PMU_LOW
                           || pmu_mode == smi_pend_pkg::PMU_DOZE);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      slow_q <= 1'b0;
      step_q <= 1'b0;
    end else if (clk_en) begin
      slow_q <= pmu_ctrl2_q[smi_pend_pkg::PC2_SLOW_BIT]
                && !pin_sync_q.bl1_n && !pin_sync_q.ac_present;
      step_q <= refresh_pulse && step_wanted && !step_paused;
    end
  end

  assign slow_clock_force = slow_q;
  assign force_step_down  = step_q;

  // Read port, data in the cycle after the strobe
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = smi_pend_pkg::RD_UNMAPPED;
    unique case (reg_req.addr)
      smi_pend_pkg::IDX_REGISTER_A: begin
        rd_mux = '0;
        rd_mux[smi_pend_pkg::RA_IO_BASE_BIT +: NUM_IO] = io_status_q;
        rd_mux[smi_pend_pkg::RA_PMU_BIT] = pmu_req_q;
      end
      smi_pend_pkg::IDX_MEM_SPACE_CTRL: rd_mux = mem_ctrl_q;
      smi_pend_pkg::IDX_SRC_ENABLE:     rd_mux = src_enable_q;
      smi_pend_pkg::IDX_CPU_STATUS: begin
        rd_mux = '0;
        rd_mux[smi_pend_pkg::CS_BATT_BASE_BIT +: smi_pend_pkg::NUM_BATT] = batt_lvl;
      end
      smi_pend_pkg::IDX_SMI_EVENT: begin
        rd_mux = '0;
        rd_mux[smi_pend_pkg::EV_BATT_BASE_BIT +: smi_pend_pkg::NUM_BATT] = event_q;
      end
      smi_pend_pkg::IDX_PMU_CTRL2:      rd_mux = pmu_ctrl2_q;
      smi_pend_pkg::IDX_FUNC_ENABLE:    rd_mux = func_enable_q;
      smi_pend_pkg::IDX_MISC_STATUS: begin
        rd_mux = '0;
        rd_mux[smi_pend_pkg::MS_EXT_LEVEL_BIT] = pin_sync_q.ext_req;
      end
      default: rd_mux = smi_pend_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

endmodule // smi_pending_ext_battery_logic
`default_nettype wire

// >>> smi_pend_pkg.sv
// Package for the SMI pending / external SMI / battery-level block.
// Assumes an 8-bit register port with index addresses and one 100 MHz clock.
`default_nettype none

package smi_pend_pkg;

  // Clock figures
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register indexes
  localparam logic [7:0] IDX_REGISTER_A      = 8'h43;
  localparam logic [7:0] IDX_MEM_SPACE_CTRL  = 8'h74;
  localparam logic [7:0] IDX_SRC_ENABLE      = 8'h82;
  localparam logic [7:0] IDX_SOCKET_STATUS   = 8'hA2;
  localparam logic [7:0] IDX_CPU_STATUS      = 8'hA3;
  localparam logic [7:0] IDX_SMI_EVENT       = 8'hA5;
  localparam logic [7:0] IDX_PMU_CTRL2       = 8'hAF;
  localparam logic [7:0] IDX_FUNC_ENABLE     = 8'hB0;
  localparam logic [7:0] IDX_MISC_STATUS     = 8'hB3;

  // Field positions
  localparam int unsigned FE_EXT_EN_BIT      = 4;
  localparam int unsigned FE_EXT_POL_BIT     = 5;
  localparam int unsigned MS_EXT_LEVEL_BIT   = 1;
  localparam int unsigned PC2_SLOW_BIT       = 5;
  localparam int unsigned MSC_NO_SLEEP_BIT   = 6;
  localparam int unsigned SE_LOW_DOZE_BIT    = 1;
  localparam int unsigned SE_DOZE_SLEEP_BIT  = 2;
  localparam int unsigned SE_BATT_BASE_BIT   = 5;
  localparam int unsigned EV_BATT_BASE_BIT   = 5;
  localparam int unsigned CS_BATT_BASE_BIT   = 0;
  localparam int unsigned RA_IO_BASE_BIT     = 0;
  localparam int unsigned RA_PMU_BIT         = 5;
  localparam int unsigned NUM_IO_SRC         = 5;
  localparam int unsigned NUM_BATT           = 3;

  // Reset values
  localparam logic [7:0] RST_SRC_ENABLE      = 8'h00;
  localparam logic [7:0] RST_FUNC_ENABLE     = 8'h00;
  localparam logic [7:0] RST_PMU_CTRL2       = 8'h00;
  localparam logic [7:0] RST_MEM_SPACE_CTRL  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED         = 8'h00;

  typedef enum logic [2:0] {
    PMU_HIGH    = 3'b000,
    PMU_LOW     = 3'b001,
    PMU_DOZE    = 3'b010,
    PMU_SLEEP   = 3'b011,
    PMU_SUSPEND = 3'b100,
    PMU_OFF     = 3'b101
  } pmu_mode_t;

  typedef enum logic [1:0] {
    SMI_IDLE    = 2'b00,
    SMI_ASSERT  = 2'b01,
    SMI_SERVICE = 2'b10
  } smi_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic ac_present;
    logic bl4_n;
    logic bl3_n;
    logic bl2_n;
    logic bl1_n;
    logic ext_req;
  } pin_group_t;

endpackage
`default_nettype wire

// >>> smi_pend_properties.sv
// Concurrent checks on the SMI pending, external request and battery block.
// Assumes one clock and a design attached through the bind below.
`timescale 1ns/1ps
`default_nettype none

module smi_pend_properties #(
  parameter int unsigned NUM_IO = 5
) (
  input wire logic                     core_clk,
  input wire logic                     srst,
  input wire logic                     clk_en,
  input wire smi_pend_pkg::reg_req_t   reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire smi_pend_pkg::pin_group_t pins,
  input wire logic [NUM_IO-1:0]        io_decode_smi,
  input wire logic                     smi_active,
  input wire logic                     refresh_pulse,
  input wire smi_pend_pkg::pmu_mode_t  pmu_mode,
  input wire logic                     cpu_clock_stopped,
  input wire logic                     smi_request,
  input wire logic                     cpu_clock_force_run,
  input wire logic                     slow_clock_force,
  input wire logic                     force_step_down
);
  logic ext_en_q;
  logic ext_pol_q;
  logic slow_en_q;
  logic no_sleep_q;
  logic ext_act;
  logic rd_misc;

  assign ext_act = pins.ext_req ^ ext_pol_q;
  assign rd_misc = reg_req.rd && (reg_req.addr == 8'hB3);

  // Shadow of the control bits that the checks depend on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      {ext_en_q, ext_pol_q, slow_en_q, no_sleep_q} <= 4'h0;
    end else if (clk_en && reg_req.wr) begin
      if (reg_req.addr == 8'hB0) begin
        ext_en_q  <= reg_req.wdata[4];
        ext_pol_q <= reg_req.wdata[5];
      end
      if (reg_req.addr == 8'hAF) begin
        slow_en_q <= reg_req.wdata[5];
      end
      if (reg_req.addr == 8'h74) begin
        no_sleep_q <= reg_req.wdata[6];
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || !clk_en);

  // A polarity change is not a pin edge, so it does not start the sequence
  sequence ext_rise_s;
    ext_en_q && !ext_act && !smi_active && !smi_request ##1 (ext_act && $stable(ext_pol_q) && !smi_active)[*4];
  endsequence
  sequence ext_held_s;
    (ext_en_q && ext_act)[*4] ##0 $fell(smi_active);
  endsequence

  a_req_drops: assert property (smi_active |=> !smi_request)
    else $error("request still high after handler entry");
  a_ext_edge: assert property (ext_rise_s |-> ##[0:2] smi_request)
    else $error("external edge raised no request");
  a_ext_repeat: assert property (ext_held_s |=> smi_request)
    else $error("held external request not repeated");
  a_misc_level: assert property ($stable(pins.ext_req)[*3] ##0 rd_misc |=> reg_rdata[1] == $past(pins.ext_req))
    else $error("status bit does not follow external pin");
  a_slow_on: assert property ((slow_en_q && !pins.bl1_n && !pins.ac_present)[*5] |-> slow_clock_force)
    else $error("slow clock not forced");
  a_slow_ac: assert property (pins.ac_present[*5] |-> !slow_clock_force)
    else $error("slow clock forced with external power");
  a_step_cause: assert property (force_step_down |-> $past(refresh_pulse) && !$past(no_sleep_q)
    && ($past(pmu_mode) inside {smi_pend_pkg::PMU_HIGH, smi_pend_pkg::PMU_LOW, smi_pend_pkg::PMU_DOZE}))
    else $error("step down without its cause");
  a_step_ac: assert property (pins.ac_present[*5] |-> !force_step_down)
    else $error("step down with external power");
  a_run_release: assert property ($fell(cpu_clock_force_run) |-> $past(refresh_pulse))
    else $error("clock run released off refresh");
endmodule // smi_pend_properties

bind smi_pending_ext_battery_logic smi_pend_properties #(.NUM_IO(NUM_IO)) props_u (
  .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .pins(pins), .io_decode_smi(io_decode_smi), .smi_active(smi_active), .refresh_pulse(refresh_pulse),
  .pmu_mode(pmu_mode), .cpu_clock_stopped(cpu_clock_stopped), .smi_request(smi_request),
  .cpu_clock_force_run(cpu_clock_force_run), .slow_clock_force(slow_clock_force),
  .force_step_down(force_step_down));
`default_nettype wire

// >>> smi_far_side.sv
// Far-side model: CPU handler entry and exit, devices on the shared request wire.
// Assumes the bench commands device raise and release and handler exit.
`timescale 1ns/1ps
`default_nettype none

module smi_far_side (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       smi_request,
  input  wire logic       handler_done,
  input  wire logic       slow,
  input  wire logic       ext_pol,
  input  wire logic [1:0] dev_set,
  input  wire logic [1:0] dev_clr,
  output logic            smi_active,
  output logic            ext_line
);
  logic [1:0] dev_q;
  logic [1:0] lat_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dev_q <= 2'h0;
    end else begin
      dev_q <= (dev_q | dev_set) & ~dev_clr;
    end
  end

  // Open drain: the pull leaves the wire at the inactive level
  assign ext_line = ext_pol ? ~|dev_q : |dev_q;

  // Slow entry models a CPU that finishes its current instruction first
  always_ff @(posedge core_clk) begin
    if (srst || handler_done) begin
      smi_active <= 1'b0;
      lat_q      <= 2'h0;
    end else if (smi_request && !smi_active) begin
      lat_q <= lat_q + 2'h1;
      if (!slow || lat_q == 2'h2) begin
        smi_active <= 1'b1;
      end
    end
  end
endmodule // smi_far_side
`default_nettype wire

// >>> smi_pending_ext_battery_logic_tb.sv
// Self-checking bench for the SMI pending, external request and battery block.
// Assumes the far-side model and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none

module smi_pending_ext_battery_logic_tb;
  logic                     core_clk;
  logic                     srst;
  logic                     clk_en;
  smi_pend_pkg::reg_req_t   reg_req;
  logic [7:0]               reg_rdata;
  smi_pend_pkg::pin_group_t pins;
  logic [4:0]               io_dec;
  logic                     smi_active;
  logic                     refresh;
  smi_pend_pkg::pmu_mode_t  mode;
  logic                     clk_stopped;
  logic                     smi_request;
  logic                     force_run;
  logic                     slow_force;
  logic                     step_down;
  logic                     ac;
  logic [3:0]               bl_n;
  logic                     ext_line;
  logic                     ext_pol;
  logic                     done;
  logic                     slow;
  logic [1:0]               dev_set;
  logic [1:0]               dev_clr;
  int                       mismatches;
  int                       compares;

  assign pins = {ac, bl_n, ext_line};

  smi_pending_ext_battery_logic #(.NUM_IO(5)) dut_u (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pins(pins), .io_decode_smi(io_dec), .smi_active(smi_active), .refresh_pulse(refresh),
    .pmu_mode(mode), .cpu_clock_stopped(clk_stopped), .smi_request(smi_request),
    .cpu_clock_force_run(force_run), .slow_clock_force(slow_force), .force_step_down(step_down));

  smi_far_side far_u (
    .core_clk(core_clk), .srst(srst), .smi_request(smi_request), .handler_done(done), .slow(slow),
    .ext_pol(ext_pol), .dev_set(dev_set), .dev_clr(dev_clr), .smi_active(smi_active), .ext_line(ext_line));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic pulse(input logic [1:0] s, input logic [1:0] c, input logic [4:0] io, input logic r);
    @(posedge core_clk);
    {dev_set, dev_clr, io_dec, refresh} <= {s, c, io, r};
    @(posedge core_clk);
    {dev_set, dev_clr, io_dec, refresh} <= '0;
  endtask

  task automatic expect_smi(input logic exp);
    logic got;
    got = 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      #1 got = got | smi_request;
    end
    check({7'h00, got}, {7'h00, exp});
  endtask

  task automatic end_handler;
    @(posedge core_clk);
    done <= 1'b1;
    @(posedge core_clk);
    done <= 1'b0;
  endtask

  task automatic batt_done(input logic [7:0] ev, input logic step);
    rd(8'hA5, ev);
    wr(8'hA2, 8'h00);
    wr(8'hA5, 8'h00);
    rd(8'hA5, 8'h00);
    pulse(2'h0, 2'h0, 5'h00, 1'b1);
    #1 check({7'h00, step_down}, {7'h00, step});
    check({7'h00, force_run}, 8'h00);
    end_handler;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    print_verdict;
  end

  initial begin
    {reg_req, io_dec, refresh, clk_stopped, ac, ext_pol, done, slow, dev_set, dev_clr} = '0;
    srst = 1'b1;
    clk_en = 1'b1;
    mode = smi_pend_pkg::PMU_HIGH;
    bl_n = 4'hF;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h82, 8'h00);
    rd(8'hB0, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'hA3, 8'h07);
    for (int p = 1; p >= 0; p--) begin
      wr(8'hB0, {2'h0, p[0], 5'h00});
      ext_pol <= p[0];
      wr(8'hB0, {2'h0, p[0], 5'h10});
      pulse(2'h3, 2'h0, 5'h00, 1'b0);
      expect_smi(1'b1);
      rd(8'hB3, {6'h00, ~p[0], 1'b0});
      pulse(2'h0, 2'h1, 5'h1F, 1'b0);
      end_handler;
      expect_smi(1'b1);
      pulse(2'h0, 2'h2, 5'h00, 1'b0);
      // The pin reaches the status bit through the two-stage synchroniser
      repeat (2) @(posedge core_clk);
      rd(8'hB3, {6'h00, p[0], 1'b0});
      end_handler;
      expect_smi(1'b0);
      rd(8'h43, 8'h1F);
      wr(8'h43, 8'h1F);
      rd(8'h43, 8'h00);
    end
    wr(8'hB0, 8'h00);
    pulse(2'h1, 2'h0, 5'h00, 1'b0);
    expect_smi(1'b0);
    pulse(2'h0, 2'h1, 5'h00, 1'b0);
    for (int i = 0; i < 3; i += 2) begin
      wr(8'h82, 8'h20 << i);
      bl_n[i] <= 1'b0;
      expect_smi(1'b1);
      check({7'h00, force_run}, 8'h01);
      batt_done(8'h20 << i, 1'b0);
      expect_smi(1'b0);
      bl_n[i] <= 1'b1;
      expect_smi(1'b1);
      batt_done(8'h20 << i, 1'b0);
    end
    wr(8'hAF, 8'h20);
    bl_n[0] <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1 check({7'h00, slow_force}, 8'h01);
    ac <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 check({7'h00, slow_force}, 8'h00);
    {ac, slow, bl_n[0]} <= 3'h3;
    wr(8'h82, 8'h42);
    mode <= smi_pend_pkg::PMU_LOW;
    bl_n[1] <= 1'b0;
    expect_smi(1'b1);
    pulse(2'h0, 2'h0, 5'h00, 1'b1);
    #1 check({7'h00, step_down}, 8'h00);
    batt_done(8'h40, 1'b1);
    wr(8'h74, 8'h40);
    pulse(2'h0, 2'h0, 5'h00, 1'b1);
    #1 check({7'h00, step_down}, 8'h00);
    wr(8'h74, 8'h00);
    {bl_n[1], mode} <= {1'b1, smi_pend_pkg::PMU_SLEEP};
    repeat (4) @(posedge core_clk);
    bl_n[1] <= 1'b0;
    expect_smi(1'b0);
    {bl_n[3], bl_n[1], mode} <= {2'h1, smi_pend_pkg::PMU_HIGH};
    repeat (4) @(posedge core_clk);
    bl_n[1] <= 1'b0;
    expect_smi(1'b0);
    {bl_n[3], bl_n[1], mode, clk_stopped} <= {2'h3, smi_pend_pkg::PMU_DOZE, 1'b1};
    repeat (4) @(posedge core_clk);
    bl_n[1] <= 1'b0;
    expect_smi(1'b1);
    check({7'h00, force_run}, 8'h01);
    batt_done(8'h40, 1'b1);
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(8'h82, 8'hFF);
    clk_en <= 1'b1;
    rd(8'h82, 8'h42);
    print_verdict;
  end
endmodule // smi_pending_ext_battery_logic_tb
`default_nettype wire
